// ---- dv/adcc_analog_model.sv ----
// Purpose: analog mux, comparator and rc oscillator stand-in
// Assumes: ideal comparator, one fixed level per channel
// Notes: rc runs free, phase unrelated to mclk
module adcc_analog_model import adcc_pkg::*; (
  // controls from the block
  input wire adcc_analog_s analogCtl,
  // comparator and rc clock
  output logic compHigh,
  output logic rcClock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] level;
  // each routed channel shows its own level
  assign level = {analogCtl.chanSel, 4'h0} ^ 10'h2a5;
  // input at or above trial code; off when unpowered
  assign compHigh = analogCtl.powered && level >= analogCtl.dacCode;
  // 600 ns per edge: a 1.2 us bit period, inside the rc range
  initial begin
    rcClock = 1'b0;
    #13;
    forever #600 rcClock = ~rcClock;
  end
endmodule

// ---- dv/adcc_monitor.sv ----
// Purpose: concurrent checks on the converter control ports
// Assumes: one clock domain, srst synchronous active high
// Notes: sees top ports only, bound below
module adcc_monitor import adcc_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // core and analog side
  input wire logic sleepMode,
  input wire adcc_analog_s analogCtl,
  // requests
  input wire logic wakeRequest,
  input wire logic isrRequest,
  input wire logic conversionDone
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // helpers
  // ********************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  wire logic req = cyc_i && stb_i;
  // a flag write in flight is the only legal way to clear the flag
  wire logic flagWr = req && we_i && adr_i == OFF_FLAG;
  wire logic [5:0] ch = analogCtl.chanSel;
  wire logic chOk = (ch < 6'h17 && ch[2:0] != 3'h7) || ch >= CH_AVSS;
  // ********************
  // checks
  // ********************
  ack_answer_a: assert property (req && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (!req |=> !ack_o)
    else $error("ack without request");
  rd_high_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  done_hold_a: assert property (conversionDone && !flagWr |=> conversionDone)
    else $error("done flag cleared without write");
  isr_cause_a: assert property (isrRequest |-> conversionDone)
    else $error("vector request without done flag");
  wake_cause_a: assert property (wakeRequest |-> sleepMode && conversionDone)
    else $error("wake request outside sleep or without flag");
  chan_legal_a: assert property (analogCtl.chanLegal == chOk)
    else $error("channel legality decode wrong");
endmodule

bind adcc_ctrl adcc_monitor u_mon (
  .mclk(mclk),
  .srst(srst),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .we_i(we_i),
  .adr_i(adr_i),
  .dat_o(dat_o),
  .ack_o(ack_o),
  .sleepMode(sleepMode),
  .analogCtl(analogCtl),
  .wakeRequest(wakeRequest),
  .isrRequest(isrRequest),
  .conversionDone(conversionDone)
);

// ---- dv/tb_top.sv ----
// Purpose: self-checking bench of the converter control block
// Assumes: wishbone classic master, 25 MHz mclk
// Notes: results checked only where compare latency allows
module tb_top import adcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, srst, cyc, stb, we, ack, sleepMode, compHigh, rcClock, wake, isr, done;
  logic [7:0] adr, q, hi;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [17:0] trigIn;
  logic [5:0] ch;
  logic [9:0] r;
  adcc_analog_s analogCtl;
  int failCount, nTests, cycCnt, t;
  localparam logic [2:0] CODES [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  localparam int TQ [7] = '{23, 46, 92, 184, 368, 736, 338};
  // settle wait after routing the temperature input, plain default
  localparam int TEMP_SETTLE = 40;
  adcc_ctrl uut (.mclk(mclk), .srst(srst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .sleepMode(sleepMode), .compHigh(compHigh), .rcClock(rcClock), .trigIn(trigIn),
    .analogCtl(analogCtl), .wakeRequest(wake), .isrRequest(isr), .conversionDone(done));
  adcc_analog_model u_ana (.analogCtl(analogCtl), .compHigh(compHigh), .rcClock(rcClock));
  // ********************
  // tasks
  // ********************
  task automatic summarize();
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    nTests++;
    if (g !== e) begin
      failCount++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one classic cycle, then one idle edge so outputs settle
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    wb(a, 1'b0, 8'h0);
    chk({8'h0, q}, {8'h0, e});
  endtask
  task automatic waitDone(input int lim);
    t = 0;
    while (done !== 1'b1 && t < lim) begin
      @(posedge mclk);
      t++;
    end
  endtask
  // ********************
  // clock, timeout, tests
  // ********************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // limit far above the roughly 4300 cycles of the run
  always @(posedge mclk) begin
    cycCnt++;
    if (cycCnt == 30000) begin
      failCount++;
      summarize();
    end
  end
  initial begin
    {srst, cyc, stb, we, sleepMode} = 5'h10;
    adr = 8'h0;
    sel = 4'hf;
    wdat = 32'h0;
    trigIn = 18'h0;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    rc(OFF_CTRL_A, CTRL_A_RST);
    rc(OFF_CTRL_B, CTRL_B_RST);
    wb(8'h24, 1'b1, 8'hff);
    rc(8'h24, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wb(OFF_CTRL_B, 1'b1, 8'(i));
      chk(16'({analogCtl.negRefSel, analogCtl.posRefSel}), 16'(i));
    end
    wb(OFF_CTRL_A, 1'b1, 8'h03);
    rc(OFF_CTRL_A, 8'h01);
    $display("test setup done");
    for (int i = 0; i < 7; i++) begin
      ch = 6'(i);
      r = {ch, 4'h0} ^ 10'h2a5;
      wb(OFF_CTRL_B, 1'b1, {i[0], CODES[i], 4'h0});
      wb(OFF_CTRL_A, 1'b1, {CH_AVSS, 2'b01});
      wb(OFF_CTRL_A, 1'b1, {ch, 2'b01});
      chk(16'(analogCtl.chanSel), 16'(ch));
      repeat (8) @(posedge mclk);
      wb(OFF_CTRL_A, 1'b1, {ch, 2'b11});
      chk(16'(analogCtl.sampleHold), 16'(i < 6));
      waitDone(1000);
      chk(16'(t >= TQ[i] - 2 && t <= TQ[i] + 14), 16'h1);
      rc(OFF_CTRL_A, {ch, 2'b01});
      wb(OFF_RES_HI, 1'b0, 8'h0);
      hi = q;
      wb(OFF_RES_LO, 1'b0, 8'h0);
      if (i >= 2) chk({hi, q}, i[0] ? {r, 6'h0} : {6'h0, r});
      repeat (50) @(posedge mclk);
      rc(OFF_FLAG, 8'h01);
      wb(OFF_FLAG, 1'b1, 8'h0);
      rc(OFF_FLAG, 8'h00);
    end
    wb(OFF_CTRL_A, 1'b1, {CH_TEMP, 2'b01});
    repeat (TEMP_SETTLE) @(posedge mclk);
    wb(OFF_CTRL_A, 1'b1, {CH_TEMP, 2'b11});
    waitDone(1000);
    rc(OFF_RES_HI, 8'h01);
    rc(OFF_RES_LO, 8'h75);
    wb(OFF_FLAG, 1'b1, 8'h0);
    $display("test conversions done");
    wb(OFF_IRQ_EN, 1'b1, 8'h01);
    wb(OFF_IRQ_CTL, 1'b1, 8'hc0);
    wb(OFF_CTRL_B, 1'b1, 8'h70);
    sleepMode <= 1'b1;
    wb(OFF_CTRL_A, 1'b1, 8'h0f);
    waitDone(600);
    chk({14'h0, wake, isr}, 16'h3);
    wb(OFF_IRQ_CTL, 1'b1, 8'h40);
    chk({14'h0, wake, isr}, 16'h2);
    wb(OFF_FLAG, 1'b1, 8'h0);
    wb(OFF_IRQ_EN, 1'b1, 8'h00);
    wb(OFF_CTRL_A, 1'b1, 8'h0f);
    waitDone(600);
    chk({14'h0, wake, isr}, 16'h0);
    rc(OFF_STATUS, 8'h04);
    rc(OFF_CTRL_A, 8'h0d);
    sleepMode <= 1'b0;
    wb(OFF_FLAG, 1'b1, 8'h0);
    sleepMode <= 1'b1;
    wb(OFF_CTRL_B, 1'b1, 8'h10);
    wb(OFF_CTRL_A, 1'b1, 8'h0f);
    repeat (200) @(posedge mclk);
    rc(OFF_FLAG, 8'h00);
    wb(OFF_STATUS, 1'b0, 8'h0);
    chk(16'(q[2]), 16'h1);
    sleepMode <= 1'b0;
    $display("test sleep done");
    wb(OFF_TRIG, 1'b1, 8'h01);
    wb(OFF_CTRL_A, 1'b1, 8'h0d);
    trigIn[0] <= 1'b1;
    repeat (4) @(posedge mclk);
    trigIn[0] <= 1'b0;
    waitDone(500);
    chk(16'(done), 16'h1);
    wb(OFF_FLAG, 1'b1, 8'h0);
    wb(OFF_TRIG, 1'b1, 8'h00);
    trigIn[0] <= 1'b1;
    repeat (300) @(posedge mclk);
    trigIn[0] <= 1'b0;
    chk(16'(done), 16'h0);
    $display("test trigger done");
    wb(OFF_CTRL_A, 1'b1, 8'h0f);
    repeat (20) @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    rc(OFF_CTRL_A, 8'h00);
    rc(OFF_FLAG, 8'h00);
    rc(OFF_STATUS, 8'h00);
    $display("test reset abort done");
    summarize();
  end
endmodule

// ---- rtl/adcc_ctrl.sv ----
// Purpose: control of a 10-bit successive approximation converter
// Assumes: classic wishbone slave, analog mux and comparator outside
// Notes: one answer per access, ack on the edge after request
//   divided clocks stop in sleep, so only rc conversions survive it
//   the comparator is read through two flops, so /2 decides on a stale compare; /4 and slower see the new trial
module adcc_ctrl import adcc_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // core state
  input wire logic sleepMode,
  // analog side pins
  input wire logic compHigh,
  input wire logic rcClock,
  input wire logic [17:0] trigIn,
  // analog controls
  output adcc_analog_s analogCtl,
  // wake and vector requests
  output logic wakeRequest,
  output logic isrRequest,
  output logic conversionDone
);
  adcc_main_s s_r;
  adcc_main_s s_nxt;
  logic halfTick;
  logic rcSel;
  logic powered;
  logic busy;
  logic wbHit;
  logic wrNow;
  logic [7:0] wrByte;
  logic goStart;
  logic trigEdge;
  logic abortNow;
  logic [4:0] trigIdx;

  // ********************
  // helpers
  // ********************

  // legal channel codes: seven per port plus four internal inputs
  function automatic logic chanOk(input logic [5:0] ch);
    logic [2:0] low;
    low = ch[2:0];
    chanOk = 1'b0;
    if (ch[5:3] == 3'h0 && low < CH_PER_PORT) begin
      chanOk = 1'b1;
    end
    if (ch[5:3] == CH_PORT_B[5:3] && low < CH_PER_PORT) begin
      chanOk = 1'b1;
    end
    if (ch[5:3] == CH_PORT_C[5:3] && low < CH_PER_PORT) begin
      chanOk = 1'b1;
    end
    if (ch == CH_AVSS || ch == CH_TEMP) begin
      chanOk = 1'b1;
    end
    if (ch == CH_DAC || ch == CH_FVR) begin
      chanOk = 1'b1;
    end
  endfunction

  // channel field of control word a, shared by the mux and its legality check
  function automatic logic [5:0] chanOf(input logic [7:0] ctrl);
    chanOf = ctrl[A_CHAN_LSB +: 6];
  endfunction

  // place the raw result in the register pair
  function automatic logic [15:0] justify(input logic [9:0] raw,
                                          input logic leftFmt);
    if (leftFmt) begin
      justify = {raw, 6'h00};
    end else begin
      justify = {6'h00, raw};
    end
  endfunction

  // read mux; unmapped words answer zero
  function automatic logic [7:0] regRead(input logic [7:0] adr,
                                         input adcc_main_s s,
                                         input logic bz,
                                         input logic pw);
    case (adr)
      OFF_CTRL_A: regRead = s.ctrlA;
      OFF_CTRL_B: regRead = s.ctrlB;
      OFF_RES_HI: regRead = s.resPair[15:8];
      OFF_RES_LO: regRead = s.resPair[7:0];
      OFF_FLAG: regRead = {7'h00, s.doneFlag};
      OFF_IRQ_EN: regRead = {7'h00, s.irqEn};
      OFF_IRQ_CTL: regRead = {s.global_irq_enable, s.peripheral_irq_enable, 6'h00};
      OFF_TRIG: regRead = {3'h0, s.trigSel};
      OFF_STATUS: regRead = {5'h00, s.offInSleep, pw, bz};
      default: regRead = 8'h00;
    endcase
  endfunction

  // ********************
  // conversion clock
  // ********************

  // only runs once the sample phase begins
  // holding it in the rc delay keeps the full 1.5 periods of sampling
  adcc_tick_gen u_tick (
    .mclk(mclk),
    .srst(srst),
    .run(busy && s_r.state != ST_DELAY),
    .clkSel(s_r.ctrlB[B_CLK_LSB +: 3]),
    .rcClock(rcClock),
    .halfTick(halfTick)
  );

  // ********************
  // decode
  // ********************

  // shorthand terms for the next-state logic
  always_comb begin
    rcSel = s_r.ctrlB[B_CLK_LSB +: 2] == CLK_RC_LOW;
    powered = s_r.ctrlA[A_ON_BIT] && !s_r.offInSleep;
    busy = s_r.state != ST_IDLE;
    wbHit = cyc_i && stb_i;
    wrNow = wbHit && s_r.ack && we_i && sel_i[0]; // write lands on the ack edge
    wrByte = dat_i[7:0];
    trigIdx = s_r.trigSel - 5'h01;
  end

  // start and abort causes
  always_comb begin
    goStart = 1'b0;
    if (wrNow && adr_i == OFF_CTRL_A && wrByte[A_GO_BIT]) begin
      // the same write may not also switch the converter on
      goStart = s_r.ctrlA[A_ON_BIT] && wrByte[A_ON_BIT] && powered;
    end
    trigEdge = 1'b0;
    // reserved codes above the source count never fire
    if (s_r.trigSel != TRIG_RST && s_r.trigSel <= 5'(TRIG_SRC_COUNT)) begin
      trigEdge = s_r.trgS2[trigIdx] && !s_r.trgS3[trigIdx];
    end
    trigEdge = trigEdge && !sleepMode && powered;
    abortNow = 1'b0;
    if (busy && wrNow && adr_i == OFF_CTRL_A) begin
      // clearing go or on drops the conversion
      abortNow = !wrByte[A_GO_BIT] || !wrByte[A_ON_BIT];
    end
  end

  // ********************
  // next state
  // ********************

  // bus, registers and sequencer in one pass; hardware sets come last
  always_comb begin
    s_nxt = s_r;
    // input synchronisers
    s_nxt.cmpS1 = compHigh;
    s_nxt.cmpS2 = s_r.cmpS1;
    s_nxt.trgS1 = trigIn;
    s_nxt.trgS2 = s_r.trgS1;
    s_nxt.trgS3 = s_r.trgS2;
    // bus answer, registered read data
    s_nxt.ack = wbHit && !s_r.ack;
    if (wbHit && !s_r.ack) begin
      s_nxt.rdData = regRead(adr_i, s_r, busy, powered);
    end
    // software writes
    // applied before the sequencer so a completion beats a flag clear
    if (wrNow) begin
      case (adr_i)
        OFF_CTRL_A: begin
          s_nxt.ctrlA = wrByte; // channel select
          s_nxt.ctrlA[A_GO_BIT] = busy ? wrByte[A_GO_BIT] : goStart;
        end
        OFF_CTRL_B: begin
          s_nxt.ctrlB[1:0] = wrByte[1:0]; // positive reference
          s_nxt.ctrlB[B_NEG_BIT] = wrByte[B_NEG_BIT];
          s_nxt.ctrlB[3] = 1'b0; // unused, reads zero
          s_nxt.ctrlB[B_CLK_LSB +: 3] = wrByte[B_CLK_LSB +: 3];
          s_nxt.ctrlB[B_FMT_BIT] = wrByte[B_FMT_BIT];
        end
        OFF_FLAG: s_nxt.doneFlag = wrByte[0]; // only path that clears
        OFF_IRQ_EN: s_nxt.irqEn = wrByte[0];
        OFF_IRQ_CTL: begin
          s_nxt.global_irq_enable = wrByte[CTL_GIE_BIT];
          s_nxt.peripheral_irq_enable = wrByte[CTL_PERIPHERAL_IRQ_ENABLE_BIT];
        end
        OFF_TRIG: s_nxt.trigSel = wrByte[4:0];
        default: begin
        end
      endcase
    end
    // leaving sleep powers the converter back up
    if (!sleepMode) begin
      s_nxt.offInSleep = 1'b0;
    end
    // sequencer
    // starts are taken only from idle; a request while busy is dropped
    case (s_r.state)
      ST_IDLE: begin
        if (goStart || trigEdge) begin
          s_nxt.ctrlA[A_GO_BIT] = 1'b1;
          s_nxt.dlyCnt = 3'h0;
          s_nxt.halfCnt = 2'h0;
          // rc clock waits one instruction so sleep can be entered
          s_nxt.state = rcSel ? ST_DELAY : ST_SAMPLE;
        end
      end
      ST_DELAY: begin
        // one instruction worth of mclk cycles
        s_nxt.dlyCnt = s_r.dlyCnt + 3'h1;
        if (s_r.dlyCnt == INSTR_CYCLES - 3'h1) begin
          s_nxt.state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        // first 1.5 bit periods hold the sample
        if (halfTick) begin
          s_nxt.halfCnt = s_r.halfCnt + 2'h1;
          if (s_r.halfCnt == SAMPLE_HALVES - 2'h1) begin
            s_nxt.state = ST_CONVERT;
            s_nxt.bitIdx = 4'(RES_BITS - 1);
            s_nxt.trial = 10'h200;
            s_nxt.phase = 1'b0;
          end
        end
      end
      ST_CONVERT: begin
        // one bit per period: trial on the first half, decide on the second
        if (halfTick) begin
          s_nxt.phase = !s_r.phase;
          if (s_r.phase) begin
            if (!s_r.cmpS2) begin
              s_nxt.trial[s_r.bitIdx] = 1'b0;
            end
            if (s_r.bitIdx == 4'h0) begin
              s_nxt.state = ST_IDLE;
              s_nxt.ctrlA[A_GO_BIT] = 1'b0;
              s_nxt.doneFlag = 1'b1; // set wins over clear
              s_nxt.resPair = justify(s_nxt.trial, s_r.ctrlB[B_FMT_BIT]);
              if (sleepMode && !s_r.irqEn) begin
                s_nxt.offInSleep = 1'b1; // on bit stays set
              end
            end else begin
              s_nxt.bitIdx = s_r.bitIdx - 4'h1;
              s_nxt.trial[s_r.bitIdx - 4'h1] = 1'b1;
            end
          end
        end
      end
      default: begin
        s_nxt.state = ST_IDLE;
      end
    endcase
    // divided clock stops in sleep: abandon and power down
    // left running, the conversion would wait forever on a stopped clock
    if (busy && sleepMode && !rcSel) begin
      s_nxt.state = ST_IDLE;
      s_nxt.ctrlA[A_GO_BIT] = 1'b0;
      s_nxt.offInSleep = 1'b1;
    end
    if (abortNow) begin
      s_nxt.state = ST_IDLE;
      s_nxt.ctrlA[A_GO_BIT] = 1'b0;
    end
  end

  // ********************
  // state register
  // ********************

  // reset drops control fields and any conversion in flight
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_r <= '0;
      s_r.ctrlA <= CTRL_A_RST;
      s_r.ctrlB <= CTRL_B_RST;
      s_r.trigSel <= TRIG_RST;
      s_r.state <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ********************
  // outputs
  // ********************

  // bus answer
  assign dat_o = {24'h000000, s_r.rdData};
  assign ack_o = s_r.ack;

  // analog controls straight from registers
  always_comb begin
    analogCtl.chanSel = chanOf(s_r.ctrlA);
    analogCtl.chanLegal = chanOk(chanOf(s_r.ctrlA));
    analogCtl.posRefSel = s_r.ctrlB[1:0];
    analogCtl.negRefSel = s_r.ctrlB[B_NEG_BIT];
    analogCtl.sampleHold = s_r.state == ST_SAMPLE;
    analogCtl.dacCode = s_r.trial;
    analogCtl.powered = powered;
  end

  // completion in sleep wakes the core once the converter and peripheral
  // enables are set; the vector also needs the global enable
  assign wakeRequest = sleepMode && s_r.doneFlag && s_r.irqEn && s_r.peripheral_irq_enable;
  assign isrRequest = s_r.doneFlag && s_r.irqEn && s_r.peripheral_irq_enable && s_r.global_irq_enable;
  assign conversionDone = s_r.doneFlag;
endmodule

// ---- rtl/adcc_pkg.sv ----
// Purpose: shared constants and types of the converter control block
// Assumes: 25 MHz mclk, registers one per 32-bit word
// Notes: data sits in the low byte of each word
package adcc_pkg;
  // ********************
  // register offsets
  // ********************
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_RES_HI = 8'h08;
  localparam logic [7:0] OFF_RES_LO = 8'h0c;
  localparam logic [7:0] OFF_FLAG = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] OFF_IRQ_CTL = 8'h18;
  localparam logic [7:0] OFF_TRIG = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  // ********************
  // field positions
  // ********************
  localparam int A_ON_BIT = 0;
  localparam int A_GO_BIT = 1;
  localparam int A_CHAN_LSB = 2;
  localparam int B_NEG_BIT = 2;
  localparam int B_CLK_LSB = 4;
  localparam int B_FMT_BIT = 7;
  localparam int CTL_PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int CTL_GIE_BIT = 7;
  // ********************
  // reset values
  // ********************
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [4:0] TRIG_RST = 5'h00;
  // ********************
  // codes and counts
  // ********************
  localparam logic [1:0] CLK_RC_LOW = 2'h3;
  localparam int RES_BITS = 10;
  localparam int TRIG_SRC_COUNT = 18;
  localparam logic [1:0] SAMPLE_HALVES = 2'h3;
  localparam logic [5:0] CH_PORT_B = 6'h08;
  localparam logic [5:0] CH_PORT_C = 6'h10;
  localparam logic [2:0] CH_PER_PORT = 3'h7;
  localparam logic [5:0] CH_AVSS = 6'h3c;
  localparam logic [5:0] CH_TEMP = 6'h3d;
  localparam logic [5:0] CH_DAC = 6'h3e;
  localparam logic [5:0] CH_FVR = 6'h3f;
  localparam int MCLK_MHZ = 25;
  localparam int INSTR_NS = 160;
  localparam logic [2:0] INSTR_CYCLES = 3'((INSTR_NS * MCLK_MHZ + 999) / 1000);
  // ********************
  // types
  // ********************
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONVERT} adcc_state_e;
  typedef struct packed {
    logic [5:0] chanSel;
    logic chanLegal;
    logic [1:0] posRefSel;
    logic negRefSel;
    logic sampleHold;
    logic [9:0] dacCode;
    logic powered;
  } adcc_analog_s;
  typedef struct packed {
    logic ack;
    logic [7:0] rdData;
    logic [7:0] ctrlA;
    logic [7:0] ctrlB;
    logic doneFlag;
    logic irqEn;
    logic peripheral_irq_enable;
    logic global_irq_enable;
    logic [4:0] trigSel;
    logic [15:0] resPair;
    adcc_state_e state;
    logic [1:0] halfCnt;
    logic [2:0] dlyCnt;
    logic [3:0] bitIdx;
    logic phase;
    logic [9:0] trial;
    logic offInSleep;
    logic cmpS1;
    logic cmpS2;
    logic [17:0] trgS1;
    logic [17:0] trgS2;
    logic [17:0] trgS3;
  } adcc_main_s;
  typedef struct packed {
    logic rcS1;
    logic rcS2;
    logic rcSeen;
    logic [4:0] divCnt;
    logic halfTick;
  } adcc_tick_s;
endpackage

// ---- rtl/adcc_tick_gen.sv ----
// Purpose: half bit-period strobe from divided mclk or the rc clock
// Assumes: rcClock is asynchronous to mclk
// Notes: divider restarts whenever run drops
module adcc_tick_gen import adcc_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // control
  input wire logic run,
  input wire logic [2:0] clkSel,
  input wire logic rcClock,
  // strobe
  output logic halfTick
);
  adcc_tick_s s_r;
  adcc_tick_s s_nxt;

  // half-period length minus one for each divider code
  function automatic logic [4:0] halfLimit(input logic [2:0] sel);
    case (sel)
      3'h4: halfLimit = 5'h01;
      3'h1: halfLimit = 5'h03;
      3'h5: halfLimit = 5'h07;
      3'h2: halfLimit = 5'h0f;
      3'h6: halfLimit = 5'h1f;
      default: halfLimit = 5'h00;
    endcase
  endfunction

  // both rc edges count, one edge is half a bit period
  always_comb begin
    s_nxt = s_r;
    s_nxt.rcS1 = rcClock;
    s_nxt.rcS2 = s_r.rcS1;
    s_nxt.rcSeen = s_r.rcS2;
    s_nxt.halfTick = 1'b0;
    if (!run) begin
      s_nxt.divCnt = 5'h00;
    end else if (clkSel[1:0] == CLK_RC_LOW) begin
      s_nxt.halfTick = s_r.rcS2 ^ s_r.rcSeen;
    end else if (s_r.divCnt == halfLimit(clkSel)) begin
      s_nxt.divCnt = 5'h00; // follows mclk rate
      s_nxt.halfTick = 1'b1;
    end else begin
      s_nxt.divCnt = s_r.divCnt + 5'h01;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign halfTick = s_r.halfTick;
endmodule
